//--- dv/sapsel_props.sv
// port checker for the shared pin selector
`timescale 1ns/100ps
module sapsel_props
  import sapsel_pkg::*;
#(
  parameter int NUM_PINS = 16  // shared pins
) (
  input wire logic                sys_clk_i,    // clock
  input wire logic                srst_i,       // sync reset
  input wire logic                hsel_i,       // select
  input wire logic [1:0]          htrans_i,     // transfer type
  input wire logic                hwrite_i,     // write flag
  input wire logic                hready_i,     // bus ready
  input wire logic [31:0]         hrdata_o,     // read data
  input wire logic                hreadyout_o,  // slave ready
  input wire logic                hresp_o,      // response
  input wire logic [NUM_PINS-1:0] pad_i,        // pad levels
  input wire logic [NUM_PINS-1:0] pad_oe_o,     // drive enables
  input wire logic [NUM_PINS-1:0] pullup_en_o,  // pull-ups
  input wire logic [NUM_PINS-1:0] analog_sel_o, // analog owners
  input wire logic [NUM_PINS-1:0] periph_in_o   // peripheral inputs
);
  logic wr_q;  // write now in its data phase
  logic rd_a;  // read address phase this cycle
  assign rd_a = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
  // only a write data phase may move config state
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  reset_analog_a: assert property (
    $fell(srst_i) |-> &analog_sel_o) else $error("pins not analog after reset");
  reset_quiet_a: assert property (
    $fell(srst_i) |-> pad_oe_o == '0 && pullup_en_o == '0) else $error("drive after reset");
  analog_zero_a: assert property (
    (periph_in_o & analog_sel_o) == '0) else $error("analog pin reads one");
  select_write_a: assert property (
    $changed(analog_sel_o) |-> $past(wr_q)) else $error("analog select moved alone");
  pullup_write_a: assert property (
    $changed(pullup_en_o) |-> $past(wr_q)) else $error("pull-up moved alone");
  sync_level_a: assert property (
    (periph_in_o & ~$past(pad_i, 2)) == '0) else $error("input not synced pad");
  rdata_hold_a: assert property (
    $changed(hrdata_o) |-> $past(rd_a)) else $error("read data moved alone");
  bus_okay_a: assert property (
    hreadyout_o && !hresp_o) else $error("slave not ready or not okay");
  write_seen_c: cover property (wr_q);
  drive_analog_c: cover property (|(pad_oe_o & analog_sel_o));
  digital_in_c: cover property (|periph_in_o);
endmodule : sapsel_props
bind sapsel_top sapsel_props #(.NUM_PINS(NUM_PINS)) props_u (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
  .hreadyout_o(hreadyout_o), .pad_i(pad_i), .pad_oe_o(pad_oe_o),
  .pullup_en_o(pullup_en_o), .analog_sel_o(analog_sel_o), .periph_in_o(periph_in_o));

//--- dv/tb.sv
// self-checking bench for the shared pin selector
`timescale 1ns/100ps
`include "sapsel_defs.svh"
module tb
  import sapsel_pkg::*;
;
  logic         clk = 1'b0;                       // 100 mhz clock
  logic         rst = 1'b1;                       // sync reset
  logic         hsel = 1'b0, hwrite = 1'b0;       // bus controls
  logic [11:0]  haddr = 12'h000;                  // byte address
  logic [1:0]   htrans = 2'h0;                    // transfer type
  logic [2:0]   hsize = `SAPSEL_HSIZE_WORD;       // transfer size
  sapsel_word_t hwdata = 32'h0, hrdata;           // bus data
  logic         hrdy, hresp;                      // slave answer
  logic [15:0]  pad = 16'h0, pout = 16'h0, poe = 16'hffff;  // far side
  logic [15:0]  oe, po, pu, an, pin;              // pin outputs
  int           err_count = 0, checked = 0;       // tallies
  always #5 clk = ~clk;
  sapsel_top dut_u (.sys_clk_i(clk), .srst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .pad_i(pad), .pad_o(po), .pad_oe_o(oe), .pullup_en_o(pu), .analog_sel_o(an),
    .periph_out_i(pout), .periph_oe_i(poe), .periph_in_o(pin));
  // verdict and end of run
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic cmp_word(input sapsel_word_t got, input sapsel_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_pins(input logic [15:0] got, input logic [15:0] exp);
    cmp_word({16'h0, got}, {16'h0, exp});  // upper half always matches
  endtask : cmp_pins
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // one single word transfer, address then data phase
  task automatic bus(input logic [11:0] a, input logic w, input sapsel_word_t wd,
                     output sapsel_word_t rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input sapsel_word_t d);
    sapsel_word_t x;
    bus(a, 1'b1, d, x);
    @(negedge clk);  // let the write land before pins are looked at
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input sapsel_word_t exp);
    sapsel_word_t x;
    bus(a, 1'b0, 32'h0, x);
    cmp_word(x, exp);
  endtask : rd_chk
  initial begin
    sapsel_word_t tab [9] = '{32'h0, 32'h0, 32'h0000_ffff, 32'h0, 32'h0, 32'h0,
                              32'h0, 32'h0000_ffff, 32'h0};  // last is unmapped
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    pad <= 16'hffff;
    @(negedge clk);
    cmp_pins(an, 16'hffff);
    for (int i = 0; i < 9; i++) rd_chk(12'(i * 4), tab[i]);
    $display("test reset done");
    wr(`SAPSEL_OFF_PCFG0, 32'h0000_00ff);
    rd_chk(`SAPSEL_OFF_STATUS, 32'h0000_ffff);
    wr(`SAPSEL_OFF_PCFG1, 32'h0000_0f0f);
    cmp_pins(an, 16'hfff0);
    rd_chk(`SAPSEL_OFF_IN, 32'h0000_000f);
    $display("test digital done");
    wr(`SAPSEL_OFF_FUNC_EN, 32'h0000_0013);
    cmp_pins(pin, 16'h0003);
    cmp_pins(oe, 16'h0003);
    wr(`SAPSEL_OFF_OUT, 32'h0000_0f00);
    wr(`SAPSEL_OFF_DIR, 32'h0000_00ff);
    cmp_pins(oe, 16'hff03);
    cmp_pins(po & oe, 16'h0f00);
    $display("test priority done");
    @(posedge clk);
    pad <= 16'h0005;
    repeat (2) @(posedge clk);  // two sync stages before the read samples
    rd_chk(`SAPSEL_OFF_IN, 32'h0000_0005);
    cmp_pins(pin, 16'h0001);
    $display("test sync done");
    wr(`SAPSEL_OFF_PULLUP, 32'h0001_a5a5);
    cmp_pins(pu, 16'ha5a5);
    @(posedge clk);
    hsize <= 3'h0;  // byte write must be dropped
    wr(`SAPSEL_OFF_PULLUP, 32'h0);
    @(posedge clk);
    hsize <= `SAPSEL_HSIZE_WORD;
    wr(12'h040, 32'hffff_ffff);
    rd_chk(`SAPSEL_OFF_PULLUP, 32'h0000_a5a5);
    rd_chk(12'h040, 32'h0);
    $display("test pullup done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp_pins(an, 16'hffff);
    cmp_pins(pu, 16'h0000);
    rd_chk(`SAPSEL_OFF_PCFG1, 32'h0);
    $display("test rereset done");
    wrap_up();
  end
endmodule : tb

//--- hdl/sapsel_defs.svh
// register offsets, reset values and field constants for the shared pin selector
`ifndef SAPSEL_DEFS_SVH
`define SAPSEL_DEFS_SVH
`define SAPSEL_OFF_PCFG0      12'h000
`define SAPSEL_OFF_PCFG1      12'h004
`define SAPSEL_OFF_DIR        12'h008
`define SAPSEL_OFF_OUT        12'h00c
`define SAPSEL_OFF_IN         12'h010
`define SAPSEL_OFF_PULLUP     12'h014
`define SAPSEL_OFF_FUNC_EN    12'h018
`define SAPSEL_OFF_STATUS     12'h01c
`define SAPSEL_PCFG_RST       32'h0000_0000
`define SAPSEL_DIR_RST        32'hffff_ffff
`define SAPSEL_ZERO_RST       32'h0000_0000
`define SAPSEL_HTRANS_NONSEQ  1
`define SAPSEL_HSIZE_WORD     3'h2
`define SAPSEL_ADDR_LSB       2
`endif

//--- hdl/sapsel_pin.sv
// per pin owner resolution, input gating and synchroniser
`timescale 1ns/100ps
module sapsel_pin
  import sapsel_pkg::*;
#(
  parameter int NUM_CONV = 2  // converters sharing the pin
) (
  input  wire logic                sys_clk_i,     // system clock
  input  wire logic                srst_i,        // sync reset, active high
  input  wire logic [NUM_CONV-1:0] digital_i,     // per converter digital mark
  input  wire logic                periph_en_i,   // lower priority function on
  input  wire logic                dir_in_i,      // 1 input, 0 output
  input  wire logic                out_val_i,     // gpio output value
  input  wire logic                periph_out_i,  // peripheral output value
  input  wire logic                periph_oe_i,   // peripheral drive enable
  input  wire logic                pad_i,         // raw pad level
  output logic                     pad_o,         // pad drive value
  output logic                     pad_oe_o,      // pad drive enable
  output logic                     analog_sel_o,  // analog owns the pin
  output logic                     in_val_o,      // digital read value
  output logic                     periph_in_o    // level seen by peripheral
);
  initial begin
    if (NUM_CONV < 1) $error("sapsel_pin needs at least one converter");
  end

  logic          meta_q;  // first sync stage, read only by sync_q
  logic          sync_q;  // second sync stage
  sapsel_owner_e owner;   // resolved pin owner

  // two stage synchroniser for the pad level
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pad_i;
      sync_q <= meta_q;
    end
  end

  // leftmost function wins; analog unless every converter says digital
  always_comb begin
    if (!(&digital_i)) begin
      owner = SAPSEL_OWN_ANALOG;
    end else if (periph_en_i) begin
      owner = SAPSEL_OWN_PERIPH;
    end else begin
      owner = SAPSEL_OWN_GPIO;
    end
  end

  assign analog_sel_o = (owner == SAPSEL_OWN_ANALOG);
  // input buffer off while analog: reads give zero
  assign in_val_o    = analog_sel_o ? 1'b0 : sync_q;
  // peripheral input only sees the pad when it owns it
  assign periph_in_o = (owner == SAPSEL_OWN_PERIPH) ? sync_q : 1'b0;

  // output driver still works under analog if direction is output
  always_comb begin
    if (owner == SAPSEL_OWN_PERIPH) begin
      pad_o    = periph_out_i;
      pad_oe_o = periph_oe_i;
    end else begin
      pad_o    = out_val_i;
      pad_oe_o = !dir_in_i;
    end
  end
endmodule : sapsel_pin

//--- hdl/sapsel_pkg.sv
// types shared by the shared pin selector files
package sapsel_pkg;
  typedef logic [31:0] sapsel_word_t;  // one bus word
  typedef enum logic [1:0] {
    SAPSEL_OWN_ANALOG,
    SAPSEL_OWN_PERIPH,
    SAPSEL_OWN_GPIO
  } sapsel_owner_e;  // which function owns a pin
endpackage : sapsel_pkg

//--- hdl/sapsel_top.sv
// shared analog/digital pin selector with ahb-lite register slave
//
// Functional notes
// - every reset returns shared pins to analog
// - analog mode switches digital input buffer off
// - analog pin reads as zero
// - config bit one enables digital input
// - digital only when all converters agree
// - output driver works despite analog mode
// - leftmost enabled function blocks lower ones
// - per pin switchable weak pull-up
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "sapsel_defs.svh"
module sapsel_top
  import sapsel_pkg::*;
#(
  parameter int NUM_PINS = 16  // shared pins
) (
  input  wire logic                sys_clk_i,      // system clock
  input  wire logic                srst_i,         // sync reset, active high
  input  wire logic                hsel_i,         // slave select
  input  wire logic [11:0]         haddr_i,        // byte address
  input  wire logic [1:0]          htrans_i,       // transfer type
  input  wire logic                hwrite_i,       // write when high
  input  wire logic [2:0]          hsize_i,        // transfer size
  input  wire logic [31:0]         hwdata_i,       // write data
  input  wire logic                hready_i,       // bus ready in
  output logic [31:0]              hrdata_o,       // read data
  output logic                     hreadyout_o,    // slave ready
  output logic                     hresp_o,        // always okay
  input  wire logic [NUM_PINS-1:0] pad_i,          // raw pad levels
  output logic [NUM_PINS-1:0]      pad_o,          // pad drive values
  output logic [NUM_PINS-1:0]      pad_oe_o,       // pad drive enables
  output logic [NUM_PINS-1:0]      pullup_en_o,    // weak pull-up enables
  output logic [NUM_PINS-1:0]      analog_sel_o,   // analog switch closed
  input  wire logic [NUM_PINS-1:0] periph_out_i,   // peripheral output values
  input  wire logic [NUM_PINS-1:0] periph_oe_i,    // peripheral drive enables
  output logic [NUM_PINS-1:0]      periph_in_o     // levels to peripherals
);
  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 32) $error("NUM_PINS must be 1..32");
  end

  localparam int NUM_CONV = 2;  // two converter config registers

  logic [NUM_PINS-1:0] pcfg0_q;    // converter_pin_config_low
  logic [NUM_PINS-1:0] pcfg1_q;    // converter_pin_config_high (second converter)
  logic [NUM_PINS-1:0] dir_q;      // pin_direction_control, 1 input
  logic [NUM_PINS-1:0] out_q;      // output latch
  logic [NUM_PINS-1:0] pullup_q;   // change_notify_pin pull-up enables
  logic [NUM_PINS-1:0] func_en_q;  // lower priority function enables
  logic [NUM_PINS-1:0] in_val;     // gated digital reads

  logic                wr_pend_q;  // data phase of a write pending
  logic                rd_pend_q;  // data phase of a read pending
  logic [11:0]         addr_q;     // latched address
  logic [31:0]         rdata_q;    // registered read data

  // widen a pin vector to a bus word, upper bits zero
  function automatic sapsel_word_t widen(input logic [NUM_PINS-1:0] v);
    sapsel_word_t w;
    w = '0;
    w[NUM_PINS-1:0] = v;
    return w;
  endfunction : widen

  // valid word access in the address phase
  logic addr_ok;
  assign addr_ok = hsel_i && hready_i && htrans_i[1] &&
                   (hsize_i == `SAPSEL_HSIZE_WORD);

  // zero wait state slave: always ready, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;

  // address phase capture
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite_i;
      rd_pend_q <= addr_ok && !hwrite_i;
      if (addr_ok) begin
        addr_q <= haddr_i;
      end
    end
  end

  // converter config registers; reset puts all pins analog
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pcfg0_q <= NUM_PINS'(`SAPSEL_PCFG_RST);
      pcfg1_q <= NUM_PINS'(`SAPSEL_PCFG_RST);
    end else if (wr_pend_q) begin
      if (addr_q == `SAPSEL_OFF_PCFG0) begin
        pcfg0_q <= hwdata_i[NUM_PINS-1:0];
      end else if (addr_q == `SAPSEL_OFF_PCFG1) begin
        pcfg1_q <= hwdata_i[NUM_PINS-1:0];
      end
    end
  end

  // direction and output latch; inputs by default
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dir_q <= NUM_PINS'(`SAPSEL_DIR_RST);
      out_q <= NUM_PINS'(`SAPSEL_ZERO_RST);
    end else if (wr_pend_q) begin
      if (addr_q == `SAPSEL_OFF_DIR) begin
        dir_q <= hwdata_i[NUM_PINS-1:0];
      end else if (addr_q == `SAPSEL_OFF_OUT) begin
        out_q <= hwdata_i[NUM_PINS-1:0];
      end
    end
  end

  // pull-up and peripheral function enables
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pullup_q  <= NUM_PINS'(`SAPSEL_ZERO_RST);
      func_en_q <= NUM_PINS'(`SAPSEL_ZERO_RST);
    end else if (wr_pend_q) begin
      if (addr_q == `SAPSEL_OFF_PULLUP) begin
        pullup_q <= hwdata_i[NUM_PINS-1:0];
      end else if (addr_q == `SAPSEL_OFF_FUNC_EN) begin
        func_en_q <= hwdata_i[NUM_PINS-1:0];
      end
    end
  end

  assign pullup_en_o = pullup_q;

  // read data mux, registered in the address phase for next cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      if (haddr_i == `SAPSEL_OFF_PCFG0) begin
        rdata_q <= widen(pcfg0_q);
      end else if (haddr_i == `SAPSEL_OFF_PCFG1) begin
        rdata_q <= widen(pcfg1_q);
      end else if (haddr_i == `SAPSEL_OFF_DIR) begin
        rdata_q <= widen(dir_q);
      end else if (haddr_i == `SAPSEL_OFF_OUT) begin
        rdata_q <= widen(out_q);
      end else if (haddr_i == `SAPSEL_OFF_IN) begin
        rdata_q <= widen(in_val);
      end else if (haddr_i == `SAPSEL_OFF_PULLUP) begin
        rdata_q <= widen(pullup_q);
      end else if (haddr_i == `SAPSEL_OFF_FUNC_EN) begin
        rdata_q <= widen(func_en_q);
      end else if (haddr_i == `SAPSEL_OFF_STATUS) begin
        rdata_q <= widen(analog_sel_o);
      end else begin
        rdata_q <= 32'h0000_0000;  // unmapped reads zero
      end
    end
  end

  // per pin selection logic
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    sapsel_pin #(
      .NUM_CONV (NUM_CONV)
    ) u_pin (
      .sys_clk_i    (sys_clk_i),
      .srst_i       (srst_i),
      .digital_i    ({pcfg1_q[p], pcfg0_q[p]}),
      .periph_en_i  (func_en_q[p]),
      .dir_in_i     (dir_q[p]),
      .out_val_i    (out_q[p]),
      .periph_out_i (periph_out_i[p]),
      .periph_oe_i  (periph_oe_i[p]),
      .pad_i        (pad_i[p]),
      .pad_o        (pad_o[p]),
      .pad_oe_o     (pad_oe_o[p]),
      .analog_sel_o (analog_sel_o[p]),
      .in_val_o     (in_val[p]),
      .periph_in_o  (periph_in_o[p])
    );
  end

  // rd_pend_q kept for data phase tracking symmetry
  logic unused_rd;
  assign unused_rd = rd_pend_q;
endmodule : sapsel_top
